//--- core/iolc_pkg.sv
// constants for the i/o line configuration and change-interrupt block
package iolc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned STRB_W = DATA_W / 8;

  // register byte addresses
  localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] OFF_CHANGE_IRQ_DISABLE = 8'h04;
  localparam logic [7:0] OFF_CHANGE_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_CHANGE_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFF_OPEN_DRAIN_ENABLE = 8'h10;
  localparam logic [7:0] OFF_OPEN_DRAIN_DISABLE = 8'h14;
  localparam logic [7:0] OFF_OPEN_DRAIN_STATUS = 8'h18;
  localparam logic [7:0] OFF_PULLUP_DISABLE = 8'h20;
  localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h24;
  localparam logic [7:0] OFF_PULLUP_STATUS = 8'h28;
  localparam logic [7:0] OFF_FUNCTION_A_SELECT = 8'h30;
  localparam logic [7:0] OFF_FUNCTION_B_SELECT = 8'h34;
  localparam logic [7:0] OFF_FUNCTION_SELECT_STATUS = 8'h38;
  localparam logic [7:0] OFF_OUTPUT_WRITE_ENABLE = 8'h40;
  localparam logic [7:0] OFF_OUTPUT_WRITE_DISABLE = 8'h44;
  localparam logic [7:0] OFF_OUTPUT_WRITE_STATUS = 8'h48;
  localparam logic [7:0] OFF_OUTPUT_DATA_REGISTER = 8'h4C;

  // reset values, one bit per line
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DRAIN = 32'h0000_0000;
  localparam logic [31:0] RST_PULLUP_OFF = 32'h0000_0000;
  localparam logic [31:0] RST_FUNC_B = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_WRITE = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_DATA = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- core/iolc_line_if.sv
// per-line signals between the register core and the pad logic
`timescale 1ns/1ps
interface iolc_line_if #(
  parameter int unsigned N = 32
);
  logic [N-1:0] open_drain;
  logic [N-1:0] out_data;
  logic [N-1:0] drive_req;
  logic [N-1:0] change;

  modport core (
    output open_drain,
    output out_data,
    output drive_req,
    input change
  );

  modport pad (
    input open_drain,
    input out_data,
    input drive_req,
    output change
  );
endinterface

//--- core/iolc_pad_ctrl.sv
// per-line pad drive and input change detection
`timescale 1ns/1ps
module iolc_pad_ctrl #(
  parameter int unsigned N = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  iolc_line_if.pad lines,
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe
);
  logic [N-1:0] prev_level;
  logic armed;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_level <= '0;
      armed <= 1'b0;
    end else begin
      prev_level <= pad_in;
      armed <= 1'b1;
    end
  end

  // first sample after reset has no history, so it raises no change
  assign lines.change = armed ? (pad_in ^ prev_level) : '0;

  for (genvar i = 0; i < N; i++) begin : g_line
    // open drain: release instead of driving a one
    assign pad_out[i] = lines.out_data[i];
    assign pad_oe[i] = lines.drive_req[i] & (~lines.open_drain[i] | ~lines.out_data[i]);
  end
endmodule // iolc_pad_ctrl

//--- core/iolc_io_line_config_irq.sv
// i/o line configuration, change interrupt and axi4-lite register slave
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module iolc_io_line_config_irq #(
  parameter int unsigned NUM_LINES = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [iolc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [iolc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [iolc_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [iolc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [iolc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_LINES-1:0] line_drive_req,
  input wire logic [NUM_LINES-1:0] pad_in,
  output logic [NUM_LINES-1:0] pad_out,
  output logic [NUM_LINES-1:0] pad_oe,
  output logic [NUM_LINES-1:0] pullup_on,
  output logic [NUM_LINES-1:0] func_b_sel,
  output logic irq
);
  if (NUM_LINES < 1 || NUM_LINES > iolc_pkg::DATA_W) begin : g_bad_lines
    $error("NUM_LINES must lie between 1 and the data width");
  end

  localparam logic [NUM_LINES-1:0] RST_MASK = iolc_pkg::RST_IRQ_MASK[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_STAT = iolc_pkg::RST_IRQ_STATUS[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_OD = iolc_pkg::RST_OPEN_DRAIN[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_PU = iolc_pkg::RST_PULLUP_OFF[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_FB = iolc_pkg::RST_FUNC_B[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_OW = iolc_pkg::RST_OUT_WRITE[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] RST_OD_DATA = iolc_pkg::RST_OUT_DATA[NUM_LINES-1:0];

  // ---------------- write channel capture ----------------
  logic aw_held;
  logic w_held;
  logic [iolc_pkg::ADDR_W-1:0] wr_addr;
  logic [iolc_pkg::DATA_W-1:0] wr_data;
  logic [iolc_pkg::STRB_W-1:0] wr_strb;
  logic bvalid;
  logic [1:0] bresp;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  // one write under way: both halves held and no answer pending
  wire wr_fire = aw_held & w_held & ~bvalid;

  assign s_axi_awready = ~aw_held & ~bvalid;
  assign s_axi_wready = ~w_held & ~bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (w_take) begin
      w_held <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // ---------------- write decode ----------------
  wire wsel_ier = wr_fire & (wr_addr == iolc_pkg::OFF_CHANGE_IRQ_ENABLE);
  wire wsel_idr = wr_fire & (wr_addr == iolc_pkg::OFF_CHANGE_IRQ_DISABLE);
  wire wsel_imr = wr_fire & (wr_addr == iolc_pkg::OFF_CHANGE_IRQ_MASK);
  wire wsel_isr = wr_fire & (wr_addr == iolc_pkg::OFF_CHANGE_IRQ_STATUS);
  wire wsel_ode = wr_fire & (wr_addr == iolc_pkg::OFF_OPEN_DRAIN_ENABLE);
  wire wsel_odd = wr_fire & (wr_addr == iolc_pkg::OFF_OPEN_DRAIN_DISABLE);
  wire wsel_ods = wr_fire & (wr_addr == iolc_pkg::OFF_OPEN_DRAIN_STATUS);
  wire wsel_pud = wr_fire & (wr_addr == iolc_pkg::OFF_PULLUP_DISABLE);
  wire wsel_pue = wr_fire & (wr_addr == iolc_pkg::OFF_PULLUP_ENABLE);
  wire wsel_pus = wr_fire & (wr_addr == iolc_pkg::OFF_PULLUP_STATUS);
  wire wsel_fa = wr_fire & (wr_addr == iolc_pkg::OFF_FUNCTION_A_SELECT);
  wire wsel_fb = wr_fire & (wr_addr == iolc_pkg::OFF_FUNCTION_B_SELECT);
  wire wsel_fs = wr_fire & (wr_addr == iolc_pkg::OFF_FUNCTION_SELECT_STATUS);
  wire wsel_owe = wr_fire & (wr_addr == iolc_pkg::OFF_OUTPUT_WRITE_ENABLE);
  wire wsel_owd = wr_fire & (wr_addr == iolc_pkg::OFF_OUTPUT_WRITE_DISABLE);
  wire wsel_ows = wr_fire & (wr_addr == iolc_pkg::OFF_OUTPUT_WRITE_STATUS);
  wire wsel_odr = wr_fire & (wr_addr == iolc_pkg::OFF_OUTPUT_DATA_REGISTER);

  // read-only registers take writes silently; only unmapped ones give an error
  wire wr_mapped = wsel_ier | wsel_idr | wsel_imr | wsel_isr | wsel_ode | wsel_odd
                 | wsel_ods | wsel_pud | wsel_pue | wsel_pus | wsel_fa | wsel_fb
                 | wsel_fs | wsel_owe | wsel_owd | wsel_ows | wsel_odr;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= iolc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? iolc_pkg::RESP_OKAY : iolc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid <= 1'b0;
    end
  end

  // byte lanes with strobe low count as zero bits, so they change nothing
  logic [iolc_pkg::DATA_W-1:0] lane_mask;
  for (genvar b = 0; b < iolc_pkg::STRB_W; b++) begin : g_lane
    assign lane_mask[b*8 +: 8] = {8{wr_strb[b]}};
  end
  wire [iolc_pkg::DATA_W-1:0] wr_bits_full = wr_data & lane_mask;
  wire [NUM_LINES-1:0] wr_bits = wr_bits_full[NUM_LINES-1:0];
  wire [NUM_LINES-1:0] wr_lanes = lane_mask[NUM_LINES-1:0];

  // ---------------- line state ----------------
  logic [NUM_LINES-1:0] irq_mask;
  logic [NUM_LINES-1:0] irq_status;
  logic [NUM_LINES-1:0] open_drain;
  logic [NUM_LINES-1:0] pullup_off;
  logic [NUM_LINES-1:0] func_b;
  logic [NUM_LINES-1:0] out_write;
  logic [NUM_LINES-1:0] out_data;

  iolc_line_if #(.N(NUM_LINES)) lines ();

  wire [NUM_LINES-1:0] clr_ier = wsel_ier ? wr_bits : '0;
  wire [NUM_LINES-1:0] clr_idr = wsel_idr ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_irq_mask = (irq_mask | clr_ier) & ~clr_idr;

  wire [NUM_LINES-1:0] set_ode = wsel_ode ? wr_bits : '0;
  wire [NUM_LINES-1:0] set_odd = wsel_odd ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_open_drain = (open_drain | set_ode) & ~set_odd;

  wire [NUM_LINES-1:0] set_pud = wsel_pud ? wr_bits : '0;
  wire [NUM_LINES-1:0] set_pue = wsel_pue ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_pullup_off = (pullup_off | set_pud) & ~set_pue;

  wire [NUM_LINES-1:0] set_fb = wsel_fb ? wr_bits : '0;
  wire [NUM_LINES-1:0] set_fa = wsel_fa ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_func_b = (func_b | set_fb) & ~set_fa;

  wire [NUM_LINES-1:0] set_owe = wsel_owe ? wr_bits : '0;
  wire [NUM_LINES-1:0] set_owd = wsel_owd ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_out_write = (out_write | set_owe) & ~set_owd;

  // direct data writes reach only lines whose write gate is open
  wire [NUM_LINES-1:0] odr_upd = wsel_odr ? (out_write & wr_lanes) : '0;
  wire [NUM_LINES-1:0] next_out_data = (out_data & ~odr_upd) | (wr_bits & odr_upd);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= RST_MASK;
      open_drain <= RST_OD;
      pullup_off <= RST_PU;
      func_b <= RST_FB;
      out_write <= RST_OW;
      out_data <= RST_OD_DATA;
    end else begin
      irq_mask <= next_irq_mask;
      open_drain <= next_open_drain;
      pullup_off <= next_pullup_off;
      func_b <= next_func_b;
      out_write <= next_out_write;
      out_data <= next_out_data;
    end
  end

  // ---------------- read channel ----------------
  logic rvalid;
  logic [1:0] rresp;
  logic [iolc_pkg::DATA_W-1:0] rdata;

  assign s_axi_arready = ~rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  wire rd_fire = s_axi_arvalid & s_axi_arready;

  wire rsel_ier = s_axi_araddr == iolc_pkg::OFF_CHANGE_IRQ_ENABLE;
  wire rsel_idr = s_axi_araddr == iolc_pkg::OFF_CHANGE_IRQ_DISABLE;
  wire rsel_imr = s_axi_araddr == iolc_pkg::OFF_CHANGE_IRQ_MASK;
  wire rsel_isr = s_axi_araddr == iolc_pkg::OFF_CHANGE_IRQ_STATUS;
  wire rsel_ode = s_axi_araddr == iolc_pkg::OFF_OPEN_DRAIN_ENABLE;
  wire rsel_odd = s_axi_araddr == iolc_pkg::OFF_OPEN_DRAIN_DISABLE;
  wire rsel_ods = s_axi_araddr == iolc_pkg::OFF_OPEN_DRAIN_STATUS;
  wire rsel_pud = s_axi_araddr == iolc_pkg::OFF_PULLUP_DISABLE;
  wire rsel_pue = s_axi_araddr == iolc_pkg::OFF_PULLUP_ENABLE;
  wire rsel_pus = s_axi_araddr == iolc_pkg::OFF_PULLUP_STATUS;
  wire rsel_fa = s_axi_araddr == iolc_pkg::OFF_FUNCTION_A_SELECT;
  wire rsel_fb = s_axi_araddr == iolc_pkg::OFF_FUNCTION_B_SELECT;
  wire rsel_fs = s_axi_araddr == iolc_pkg::OFF_FUNCTION_SELECT_STATUS;
  wire rsel_owe = s_axi_araddr == iolc_pkg::OFF_OUTPUT_WRITE_ENABLE;
  wire rsel_owd = s_axi_araddr == iolc_pkg::OFF_OUTPUT_WRITE_DISABLE;
  wire rsel_ows = s_axi_araddr == iolc_pkg::OFF_OUTPUT_WRITE_STATUS;
  wire rsel_odr = s_axi_araddr == iolc_pkg::OFF_OUTPUT_DATA_REGISTER;

  // write-only registers read as zero with an okay answer
  wire rd_wo = rsel_ier | rsel_idr | rsel_ode | rsel_odd | rsel_pud | rsel_pue
             | rsel_fa | rsel_fb | rsel_owe | rsel_owd;
  wire rd_mapped = rd_wo | rsel_imr | rsel_isr | rsel_ods | rsel_pus | rsel_fs
                 | rsel_ows | rsel_odr;

  wire [NUM_LINES-1:0] rd_line =
      rsel_imr ? irq_mask :
      rsel_isr ? irq_status :
      rsel_ods ? open_drain :
      rsel_pus ? pullup_off :
      rsel_fs ? func_b :
      rsel_ows ? out_write :
      rsel_odr ? out_data : '0;
  wire [iolc_pkg::DATA_W-1:0] rd_word = iolc_pkg::DATA_W'(rd_line);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rresp <= iolc_pkg::RESP_OKAY;
      rdata <= '0;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rresp <= rd_mapped ? iolc_pkg::RESP_OKAY : iolc_pkg::RESP_SLVERR;
      rdata <= rd_word;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---------------- change status ----------------
  // read clears and write-one clears; a change in the same cycle still wins
  wire [NUM_LINES-1:0] isr_rd_clr = (rd_fire & rsel_isr) ? '1 : '0;
  wire [NUM_LINES-1:0] isr_wr_clr = wsel_isr ? wr_bits : '0;
  wire [NUM_LINES-1:0] next_irq_status =
      (irq_status & ~(isr_rd_clr | isr_wr_clr)) | lines.change;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= RST_STAT;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ---------------- pad side ----------------
  assign lines.open_drain = open_drain;
  assign lines.out_data = out_data;
  assign lines.drive_req = line_drive_req;

  iolc_pad_ctrl #(.N(NUM_LINES)) u_pad (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .lines(lines.pad),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe)
  );

  assign pullup_on = ~pullup_off;
  assign func_b_sel = func_b;
endmodule // iolc_io_line_config_irq

//--- dv/iolc_pins_model.sv
// pin-side model: resolves each line from pad drive, far drivers and pull-ups
`timescale 1ns/1ps
module iolc_pins_model #(
  parameter int unsigned N = 32
) (
  input wire logic ref_clk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pullup_on,
  input wire logic [N-1:0] ext_oe,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] lvl;
  // undriven line without pull-up floats: show inverse of last sample
  assign lvl = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
             | (~pad_oe & ~ext_oe & (pullup_on | ~pad_in));
  initial pad_in = {N{1'b0}};
  always @(posedge ref_clk) begin
    pad_in <= lvl;
  end
endmodule // iolc_pins_model

//--- dv/iolc_asserts.sv
// port-level checks for the line config and change interrupt block
`timescale 1ns/1ps
module iolc_asserts #(
  parameter int unsigned NUM_LINES = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_LINES-1:0] line_drive_req,
  input wire logic [NUM_LINES-1:0] pad_in,
  input wire logic [NUM_LINES-1:0] pad_out,
  input wire logic [NUM_LINES-1:0] pad_oe,
  input wire logic [NUM_LINES-1:0] pullup_on,
  input wire logic [NUM_LINES-1:0] func_b_sel,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_oe_needs_req: assert property ((pad_oe & ~line_drive_req) == {NUM_LINES{1'b0}})
    else $error("pad driven without request");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data not held");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_out_by_write: assert property ($changed(pad_out) |-> s_axi_bvalid)
    else $error("output data changed without write");
  a_cfg_by_write: assert property ($changed(pullup_on) || $changed(func_b_sel)
    |-> s_axi_bvalid) else $error("config changed without write");
  a_irq_rise_cause: assert property ($rose(irq) |-> s_axi_bvalid
    || $past(pad_in) != $past(pad_in, 2)) else $error("irq rose without cause");
  a_irq_fall_cause: assert property ($fell(irq) |-> s_axi_rvalid || s_axi_bvalid)
    else $error("irq fell without access");
  c_irq_rise: cover property ($rose(irq));
  c_irq_read_clear: cover property ($fell(irq) && s_axi_rvalid);
  c_pad_released: cover property (pad_oe != line_drive_req);
endmodule // iolc_asserts

bind iolc_io_line_config_irq iolc_asserts #(.NUM_LINES(NUM_LINES)) i_chk (.*);

//--- dv/iolc_io_line_config_irq_tb.sv
// self-checking bench for the line config and change interrupt block
`timescale 1ns/1ps
module iolc_io_line_config_irq_tb;
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] re;
  } iolc_row_t;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, line_drive_req = 32'hF, ext_val = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, pad_out, pad_oe, pullup_on, func_b_sel, pad_in, got;
  int n_fail = 0, tests_run = 0, cycles = 0;
  iolc_row_t rows [20] = '{
    '{8'h08, 32'hFFFF_FFFF, 8'h08, 32'h0},
    '{8'h18, 32'hFFFF_FFFF, 8'h18, 32'h0},
    '{8'h28, 32'hFFFF_FFFF, 8'h28, 32'h0},
    '{8'h38, 32'hFFFF_FFFF, 8'h38, 32'h0},
    '{8'h48, 32'hFFFF_FFFF, 8'h48, 32'h0},
    '{8'h4C, 32'hFFFF_FFFF, 8'h4C, 32'h0},
    '{8'h00, 32'hFF, 8'h08, 32'hFF},
    '{8'h04, 32'hF, 8'h08, 32'hF0},
    '{8'h10, 32'h8000_0003, 8'h18, 32'h8000_0003},
    '{8'h10, 32'h0, 8'h18, 32'h8000_0003},
    '{8'h14, 32'h8000_0001, 8'h18, 32'h2},
    '{8'h20, 32'hF0, 8'h28, 32'hF0},
    '{8'h24, 32'h30, 8'h28, 32'hC0},
    '{8'h34, 32'hF, 8'h38, 32'hF},
    '{8'h30, 32'h5, 8'h38, 32'hA},
    '{8'h40, 32'hF, 8'h48, 32'hF},
    '{8'h4C, 32'hFF, 8'h4C, 32'hF},
    '{8'h44, 32'h3, 8'h48, 32'hC},
    '{8'h4C, 32'h0, 8'h4C, 32'h3},
    '{8'h00, 32'h0, 8'h00, 32'h0}};
  always #5 ref_clk = ~ref_clk;
  iolc_io_line_config_irq i_dut (.*);
  // far drivers own lines 4..31 so no line floats into spurious changes
  iolc_pins_model i_pins (.ref_clk, .pad_out, .pad_oe, .pullup_on,
    .ext_oe(32'hFFFF_FFF0), .ext_val, .pad_in);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    got = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd, iolc_pkg::RESP_OKAY);
      rd(rows[i].ra, iolc_pkg::RESP_OKAY);
      chk(got, rows[i].re);
    end
    tick(1);
    chk(pullup_on, ~32'hC0);
    chk(func_b_sel, 32'hA);
    chk(pad_oe, 32'hD);
    chk(pad_out, 32'h3);
    rd(8'h0C, iolc_pkg::RESP_OKAY);
    ext_val <= 32'h10;
    tick(4);
    chk({31'h0, irq}, 32'h1);
    rd(8'h0C, iolc_pkg::RESP_OKAY);
    chk(got, 32'h10);
    rd(8'h0C, iolc_pkg::RESP_OKAY);
    chk(got, 32'h0);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 32'h110;
    tick(4);
    chk({31'h0, irq}, 32'h0);
    rd(8'h0C, iolc_pkg::RESP_OKAY);
    chk(got, 32'h100);
    ext_val <= 32'h130;
    tick(4);
    wr(8'h0C, 32'h20, iolc_pkg::RESP_OKAY);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    ext_val <= 32'h120;
    tick(4);
    wr(8'h04, 32'h10, iolc_pkg::RESP_OKAY);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h10, iolc_pkg::RESP_OKAY);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr(8'h1C, 32'hFFFF_FFFF, iolc_pkg::RESP_SLVERR);
    rd(8'h02, iolc_pkg::RESP_SLVERR);
    chk(got, 32'h0);
    // only byte lane 1 enabled: lines 8..15 alone may change
    s_axi_wstrb <= 4'h2;
    wr(8'h10, 32'hFFFF_FFFF, iolc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(8'h18, iolc_pkg::RESP_OKAY);
    chk(got, 32'h0000_FF02);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(1);
    chk(pullup_on, 32'hFFFF_FFFF);
    chk(func_b_sel | pad_out, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, iolc_pkg::RESP_OKAY);
    chk(got, 32'h0);
    results();
  end
endmodule // iolc_io_line_config_irq_tb
